/* logic/brc_rtc_top.sv */
// Purpose: byte-wide SRAM with BCD clock registers in the top eight bytes
// Assumes: osc_tick is a one-cycle pulse per 32768 Hz oscillator period
// Notes: bus pins are sampled each clk; a write commits when it ends

`timescale 1ns/1ps

module brc_rtc_top #(
    parameter int ADDR_W = 13,
    parameter int MEM_DEPTH = 8192
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Memory bus
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_en1_n,
    input wire logic chip_en2,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_n,
    // Supply and battery monitors
    input wire logic below_power_fail_threshold,
    input wire logic above_power_fail_threshold_max,
    input wire logic battery_check_done,
    input wire logic battery_is_low,
    // Oscillator and frequency test pin
    input wire logic osc_tick,
    output logic freq_test_out,
    output logic freq_test_oe_n
);

    // ****************************************
    // Storage and state
    // ****************************************
    logic [7:0] mem [MEM_DEPTH];
    logic protect;
    logic wr_active_q;
    logic wr_pending;
    brc_pkg::brc_write_s wr_hold;
    logic [7:0] ctrl;
    logic osc_halt_bit;
    logic frequency_test_enable;
    logic century_toggle_enable;
    logic battery_warn_enable;
    logic battery_low_flag;
    brc_pkg::brc_time_s cnt;
    brc_pkg::brc_time_s disp;
    brc_pkg::brc_time_s next_cnt;
    logic [15:0] presc;
    logic [5:0] cal_minute;
    logic write_hold_q;

    logic sel;
    logic rd_req;
    logic wr_req;
    logic wr_commit;
    logic hold;
    logic load_cnt;
    logic osc_run;
    logic sec_pulse;
    logic corr_now;
    logic [15:0] terminal;
    logic minute_wrap;
    logic [7:0] date_max;
    logic leap;
    logic [7:0] rd_data;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // ****************************************
    // Bus decode and power protection
    // ****************************************
    // Pins are ignored while protected, so a dying supply cannot
    // start or finish an access
    assign sel = !chip_en1_n && chip_en2 && !protect;
    assign rd_req = sel && write_en_n && !out_en_n;
    assign wr_req = sel && !write_en_n;
    assign wr_commit = wr_active_q && !wr_req && wr_pending && !protect;
    assign hold = ctrl[brc_pkg::CTRL_READ_BIT] ||
        ctrl[brc_pkg::CTRL_WRITE_BIT];
    assign load_cnt = write_hold_q && !ctrl[brc_pkg::CTRL_WRITE_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            protect <= 1'b1;
        end else if (below_power_fail_threshold) begin
            protect <= 1'b1;
        end else if (above_power_fail_threshold_max) begin
            protect <= 1'b0;
        end
    end

    // Write data is taken at the end of the cycle, as on a real SRAM
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_active_q <= 1'b0;
            wr_pending <= 1'b0;
            wr_hold <= '0;
        end else begin
            wr_active_q <= wr_req;
            if (wr_req) begin
                wr_pending <= 1'b1;
                wr_hold <= '{addr: addr, data: dq_in};
            end else begin
                // A write cut by power loss is dropped: only its byte is lost
                wr_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (wr_commit && wr_hold.addr < brc_pkg::ADDR_CTRL) begin
            mem[wr_hold.addr] <= wr_hold.data;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        if (addr == brc_pkg::ADDR_CTRL) begin
            rd_data = ctrl;
        end else if (addr == brc_pkg::ADDR_SEC) begin
            rd_data = {osc_halt_bit, disp.sec[6:0]};
        end else if (addr == brc_pkg::ADDR_MIN) begin
            rd_data = disp.min;
        end else if (addr == brc_pkg::ADDR_HOUR) begin
            rd_data = disp.hour;
        end else if (addr == brc_pkg::ADDR_CDAY) begin
            rd_data = {1'b0, frequency_test_enable, century_toggle_enable,
                disp.century, disp.dow[3:0]};
        end else if (addr == brc_pkg::ADDR_DATE) begin
            rd_data = {battery_warn_enable, battery_low_flag,
                disp.date[5:0]};
        end else if (addr == brc_pkg::ADDR_MONTH) begin
            rd_data = disp.month;
        end else if (addr == brc_pkg::ADDR_YEAR) begin
            rd_data = disp.year;
        end else begin
            rd_data = mem[addr];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dq_out <= 8'h00;
            dq_oe_n <= 1'b1;
        end else begin
            dq_out <= rd_data;
            dq_oe_n <= !rd_req;
        end
    end

    // ****************************************
    // Control bits written by the host
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= 8'h00;
            osc_halt_bit <= 1'b1;
            frequency_test_enable <= 1'b0;
            century_toggle_enable <= 1'b0;
            battery_warn_enable <= 1'b0;
            write_hold_q <= 1'b0;
        end else begin
            write_hold_q <= ctrl[brc_pkg::CTRL_WRITE_BIT];
            if (wr_commit) begin
                if (wr_hold.addr == brc_pkg::ADDR_CTRL) begin
                    ctrl <= wr_hold.data;
                end else if (wr_hold.addr == brc_pkg::ADDR_SEC) begin
                    osc_halt_bit <= wr_hold.data[brc_pkg::SEC_HALT_BIT];
                end else if (wr_hold.addr == brc_pkg::ADDR_CDAY) begin
                    frequency_test_enable <=
                        wr_hold.data[brc_pkg::CDAY_FT_BIT];
                    century_toggle_enable <=
                        wr_hold.data[brc_pkg::CDAY_CEB_BIT];
                end else if (wr_hold.addr == brc_pkg::ADDR_DATE) begin
                    battery_warn_enable <=
                        wr_hold.data[brc_pkg::DATE_BLE_BIT];
                end
            end
        end
    end

    // Data bit 6 of the date write is discarded on purpose
    always_ff @(posedge clk) begin
        if (rst) begin
            battery_low_flag <= 1'b0;
        end else if (battery_check_done) begin
            battery_low_flag <= battery_is_low &&
                battery_warn_enable;
        end
    end

    // ****************************************
    // Visible time registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            disp <= '0;
        end else if (wr_commit && wr_hold.addr > brc_pkg::ADDR_CTRL) begin
            // Fixed-zero bits are masked; the host is still expected
            // to write them as zero
            if (wr_hold.addr == brc_pkg::ADDR_SEC) begin
                disp.sec <= wr_hold.data & brc_pkg::MASK_SEC;
            end else if (wr_hold.addr == brc_pkg::ADDR_MIN) begin
                disp.min <= wr_hold.data & brc_pkg::MASK_MIN;
            end else if (wr_hold.addr == brc_pkg::ADDR_HOUR) begin
                disp.hour <= wr_hold.data & brc_pkg::MASK_HOUR;
            end else if (wr_hold.addr == brc_pkg::ADDR_CDAY) begin
                disp.dow <= wr_hold.data & brc_pkg::MASK_DAY;
                if (ctrl[brc_pkg::CTRL_WRITE_BIT]) begin
                    disp.century <= wr_hold.data[brc_pkg::CDAY_CB_BIT];
                end
            end else if (wr_hold.addr == brc_pkg::ADDR_DATE) begin
                disp.date <= wr_hold.data & brc_pkg::MASK_DATE;
            end else if (wr_hold.addr == brc_pkg::ADDR_MONTH) begin
                disp.month <= wr_hold.data & brc_pkg::MASK_MONTH;
            end else begin
                disp.year <= wr_hold.data;
            end
        end else if (!hold && !load_cnt) begin
            // One-cycle copy of every field keeps the set coherent
            disp <= cnt;
        end
    end

    // ****************************************
    // Prescaler with calibration
    // ****************************************
    assign osc_run = osc_tick && !osc_halt_bit;
    assign corr_now = cnt.sec == brc_pkg::BCD_ZERO &&
        {1'b0, cal_minute} < {1'b0, ctrl[4:0], 1'b0} &&
        {1'b0, cal_minute} < brc_pkg::CAL_LAST_MIN;

    always_comb begin
        if (!corr_now) begin
            terminal = brc_pkg::TICKS_NORMAL;
        end else if (ctrl[brc_pkg::CTRL_SIGN_BIT]) begin
            terminal = brc_pkg::TICKS_SHORT;
        end else begin
            terminal = brc_pkg::TICKS_LONG;
        end
    end

    // Low byte is the divide-by-256 stage; the terminal count moves
    // by whole multiples of 128 there, so corrections land at that point
    assign sec_pulse = osc_run && presc == terminal;

    always_ff @(posedge clk) begin
        if (rst || load_cnt) begin
            presc <= 16'h0000;
        end else if (sec_pulse) begin
            presc <= 16'h0000;
        end else if (osc_run) begin
            presc <= presc + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || load_cnt) begin
            cal_minute <= 6'h00;
        end else if (sec_pulse && minute_wrap) begin
            cal_minute <= cal_minute + 6'h01;
        end
    end

    // ****************************************
    // BCD calendar cascade
    // ****************************************
    assign leap = cnt.year[4] ? (cnt.year[3:0] == 4'h2 ||
        cnt.year[3:0] == 4'h6) : (cnt.year[3:0] == 4'h0 ||
        cnt.year[3:0] == 4'h4 || cnt.year[3:0] == 4'h8);

    always_comb begin
        if (cnt.month == brc_pkg::BCD_FEB) begin
            date_max = leap ? 8'h29 : 8'h28;
        end else if (cnt.month == 8'h04 || cnt.month == 8'h06 ||
            cnt.month == 8'h09 || cnt.month == 8'h11) begin
            date_max = 8'h30;
        end else begin
            date_max = 8'h31;
        end
    end

    assign minute_wrap = cnt.sec == brc_pkg::BCD_SEC_MAX;

    always_comb begin
        next_cnt = cnt;
        next_cnt.sec = bcd_inc(cnt.sec);
        if (minute_wrap) begin
            next_cnt.sec = brc_pkg::BCD_ZERO;
            next_cnt.min = bcd_inc(cnt.min);
            if (cnt.min == brc_pkg::BCD_SEC_MAX) begin
                next_cnt.min = brc_pkg::BCD_ZERO;
                next_cnt.hour = bcd_inc(cnt.hour);
                if (cnt.hour == brc_pkg::BCD_HOUR_MAX) begin
                    next_cnt.hour = brc_pkg::BCD_ZERO;
                    next_cnt.dow = cnt.dow == brc_pkg::BCD_DAY_MAX ?
                        brc_pkg::BCD_ONE : bcd_inc(cnt.dow);
                    next_cnt.date = bcd_inc(cnt.date);
                    if (cnt.date == date_max) begin
                        next_cnt.date = brc_pkg::BCD_ONE;
                        next_cnt.month = bcd_inc(cnt.month);
                        if (cnt.month == brc_pkg::BCD_MONTH_MAX) begin
                            next_cnt.month = brc_pkg::BCD_ONE;
                            next_cnt.year = bcd_inc(cnt.year);
                            if (cnt.year == brc_pkg::BCD_YEAR_MAX) begin
                                next_cnt.year = brc_pkg::BCD_ZERO;
                                next_cnt.century = cnt.century ^
                                    century_toggle_enable;
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
        end else if (load_cnt) begin
            cnt <= disp;
        end else if (sec_pulse) begin
            cnt <= next_cnt;
        end
    end

    // ****************************************
    // Frequency test pin
    // ****************************************
    // Open drain: the data bit stays low, only the enable moves
    always_ff @(posedge clk) begin
        if (rst) begin
            freq_test_out <= 1'b0;
            freq_test_oe_n <= 1'b1;
        end else begin
            freq_test_out <= 1'b0;
            freq_test_oe_n <= !(frequency_test_enable && !osc_halt_bit &&
                !presc[brc_pkg::FT_BIT]);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_hold_release;
        write_hold_q ##0 !ctrl[brc_pkg::CTRL_WRITE_BIT];
    endsequence

    a_prot_outputs: assert property (protect |=> dq_oe_n)
        else $error("output driven while protected");
    a_prot_stays: assert property (protect && !above_power_fail_threshold_max
        |=> protect)
        else $error("protection released early");
    a_read_freeze: assert property (ctrl[brc_pkg::CTRL_READ_BIT] &&
        !wr_commit |=> $stable(disp))
        else $error("registers moved during read hold");
    a_refresh_copy: assert property (!hold && !wr_commit && !load_cnt
        |=> disp == $past(cnt))
        else $error("registers not refreshed");
    a_load_keeps: assert property (load_cnt && !wr_commit |=> $stable(disp))
        else $error("registers disturbed while loading counters");
    a_load_counters: assert property (s_hold_release
        |=> cnt == $past(disp) && presc == 16'h0000)
        else $error("counters not loaded on release");
    a_halt_stops: assert property (osc_halt_bit && !load_cnt
        |=> $stable(presc) && $stable(cnt))
        else $error("counting while halted");
    a_century_keep: assert property (!century_toggle_enable && !load_cnt
        |=> $stable(cnt.century))
        else $error("century flag changed while disabled");
    a_bl_readonly: assert property (!battery_check_done
        |=> $stable(battery_low_flag))
        else $error("battery flag changed without a check");
    a_cal_window: assert property (corr_now |-> cal_minute < 6'd62 &&
        cal_minute < {ctrl[4:0], 1'b0})
        else $error("correction outside its minutes");
    a_ft_quiet: assert property (!frequency_test_enable || osc_halt_bit
        |=> freq_test_oe_n && !freq_test_out)
        else $error("test pin pulled while disabled");

endmodule

/* pkg/brc_pkg.sv */
// Purpose: constants and types for the BCD real-time clock with SRAM
// Assumes: bus pins and supply monitors arrive synchronous to clk

package brc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [12:0] ADDR_CTRL = 13'h1FF8;
    localparam logic [12:0] ADDR_SEC = 13'h1FF9;
    localparam logic [12:0] ADDR_MIN = 13'h1FFA;
    localparam logic [12:0] ADDR_HOUR = 13'h1FFB;
    localparam logic [12:0] ADDR_CDAY = 13'h1FFC;
    localparam logic [12:0] ADDR_DATE = 13'h1FFD;
    localparam logic [12:0] ADDR_MONTH = 13'h1FFE;
    localparam logic [12:0] ADDR_YEAR = 13'h1FFF;

    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int CTRL_WRITE_BIT = 7;
    localparam int CTRL_READ_BIT = 6;
    localparam int CTRL_SIGN_BIT = 5;
    localparam int SEC_HALT_BIT = 7;
    localparam int CDAY_FT_BIT = 6;
    localparam int CDAY_CEB_BIT = 5;
    localparam int CDAY_CB_BIT = 4;
    localparam int DATE_BLE_BIT = 7;
    localparam int DATE_BL_BIT = 6;
    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;

    // ****************************************
    // BCD limits
    // ****************************************
    localparam logic [7:0] BCD_SEC_MAX = 8'h59;
    localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
    localparam logic [7:0] BCD_DAY_MAX = 8'h07;
    localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
    localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_FEB = 8'h02;

    // ****************************************
    // Oscillator and calibration
    // ****************************************
    localparam int OSC_HZ = 32768;
    localparam logic [15:0] TICKS_NORMAL = 16'(OSC_HZ - 1);
    localparam logic [15:0] TICKS_SHORT = 16'(OSC_HZ - 128 - 1);
    localparam logic [15:0] TICKS_LONG = 16'(OSC_HZ + 256 - 1);
    localparam int CAL_CYCLE_MIN = 64;
    localparam logic [6:0] CAL_LAST_MIN = 7'd62;
    localparam int FT_HZ = 512;
    localparam int FT_BIT = $clog2(OSC_HZ / FT_HZ) - 1;

    typedef struct packed {
        logic century;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } brc_time_s;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] data;
    } brc_write_s;

endpackage

/* verif/brc_host.sv */
// Purpose: host bus master model for the clock SRAM
// Assumes: one access at a time, pins change 1 ns after clk rises
// Notes: released lines show the inverse of their last value

`timescale 1ns/1ps

module brc_host (
    // Clock
    input wire logic clk,
    // Bus pins
    output logic [12:0] addr,
    output logic chip_en1_n,
    output logic chip_en2,
    output logic out_en_n,
    output logic write_en_n,
    output logic [7:0] dq_in,
    // Read return
    input wire logic [7:0] dq_out,
    input wire logic dq_oe_n
);
    initial begin
        addr = 13'h0000;
        chip_en1_n = 1'b1;
        chip_en2 = 1'b0;
        out_en_n = 1'b1;
        write_en_n = 1'b1;
        dq_in = 8'h00;
    end

    // Caller hands BCD values with fixed-zero bits clear
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {chip_en1_n, chip_en2, write_en_n} = 3'b010;
        addr = a;
        dq_in = d;
        @(posedge clk) #1;
        write_en_n = 1'b1;
        @(posedge clk) #1;
        {chip_en1_n, chip_en2} = 2'b10;
        addr = ~a;
        dq_in = ~d;
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] d,
                      output logic o);
        @(posedge clk) #1;
        {chip_en1_n, chip_en2, out_en_n} = 3'b010;
        addr = a;
        @(posedge clk) #1;
        d = dq_out;
        o = dq_oe_n;
        {chip_en1_n, chip_en2, out_en_n} = 3'b101;
        addr = ~a;
    endtask
endmodule

/* verif/brc_rtc_top_test.sv */
// Purpose: self-checking bench for the clock SRAM top
// Assumes: osc_tick high every clk, so one second is 32768 cycles
// Notes: calibration minutes are too long to run here

`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module brc_rtc_top_test;
    logic clk;
    logic rst;
    logic [12:0] addr;
    logic chip_en1_n, chip_en2, out_en_n, write_en_n;
    logic [7:0] dq_in, dq_out;
    logic dq_oe_n, below, above, bat_done, bat_low, tick, ft_out, ft_oe_n;
    int err_count = 0;
    int checks = 0;
    int seed = 93012;
    int mem[int];
    int q[$];
    int n;
    logic [12:0] a;
    logic [7:0] d;
    logic bad;

    brc_rtc_top brc_rtc_top_i (.clk(clk), .rst(rst), .addr(addr),
        .chip_en1_n(chip_en1_n), .chip_en2(chip_en2), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .below_power_fail_threshold(below),
        .above_power_fail_threshold_max(above),
        .battery_check_done(bat_done), .battery_is_low(bat_low),
        .osc_tick(tick), .freq_test_out(ft_out),
        .freq_test_oe_n(ft_oe_n));

    brc_host brc_host_i (.clk(clk), .addr(addr), .chip_en1_n(chip_en1_n),
        .chip_en2(chip_en2), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk_rd(input logic [12:0] ra, input logic [7:0] e);
        logic [7:0] rd_d;
        logic rd_o;
        brc_host_i.rd(ra, rd_d, rd_o);
        `CHK({rd_o, rd_d}, {1'b0, e})
    endtask

    task automatic chk_off(input logic [12:0] ra);
        logic [7:0] rd_d;
        logic rd_o;
        brc_host_i.rd(ra, rd_d, rd_o);
        `CHK(rd_o, 1'b1)
    endtask

    // Counts test pin changes over 640 cycles, 32 cycles per half wave
    task automatic count_ft(output int cnt, output logic drove_high);
        logic prev;
        cnt = 0;
        drove_high = 1'b0;
        prev = ft_oe_n;
        repeat (640) begin
            @(posedge clk) #1;
            if (ft_oe_n !== prev) cnt++;
            if (ft_out !== 1'b0) drove_high = 1'b1;
            prev = ft_oe_n;
        end
    endtask

    task automatic close_out();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #(4 * 60000);
        err_count++;
        close_out();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, below, above, bat_done, bat_low, tick} = 6'b100001;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        chk_off(13'h0010);
        above = 1'b1;
        repeat (2) @(posedge clk);
        brc_host_i.wr(13'h0010, 8'h5A);
        {below, above} = 2'b10;
        brc_host_i.wr(13'h0010, 8'hA5);
        chk_off(13'h0010);
        below = 1'b0;
        chk_off(13'h0010);
        above = 1'b1;
        repeat (2) @(posedge clk);
        chk_rd(13'h0010, 8'h5A);
        mem[16] = 8'h5A;
        q.push_back(16);
        for (int i = 0; i < 6; i++) begin
            a = 13'($random(seed)) & 13'h0FFF;
            d = 8'($random(seed));
            mem[a] = d;
            q.push_back(a);
            brc_host_i.wr(a, d);
        end
        foreach (q[i]) chk_rd(13'(q[i]), 8'(mem[q[i]]));
        // Load 23:59:59 Sunday 31 Dec 99, century enabled
        brc_host_i.wr(brc_pkg::ADDR_CTRL, 8'h80);
        brc_host_i.wr(brc_pkg::ADDR_SEC, 8'h59);
        brc_host_i.wr(brc_pkg::ADDR_MIN, 8'h59);
        brc_host_i.wr(brc_pkg::ADDR_HOUR, 8'h23);
        brc_host_i.wr(brc_pkg::ADDR_CDAY, 8'h37);
        brc_host_i.wr(brc_pkg::ADDR_DATE, 8'hF1);
        brc_host_i.wr(brc_pkg::ADDR_MONTH, 8'h12);
        brc_host_i.wr(brc_pkg::ADDR_YEAR, 8'h99);
        brc_host_i.wr(brc_pkg::ADDR_CTRL, 8'h00);
        brc_host_i.wr(brc_pkg::ADDR_CTRL, 8'h40);
        chk_rd(brc_pkg::ADDR_CTRL, 8'h40);
        chk_rd(brc_pkg::ADDR_SEC, 8'h59);
        chk_rd(brc_pkg::ADDR_DATE, 8'hB1);
        brc_host_i.wr(brc_pkg::ADDR_CTRL, 8'h00);
        repeat (32800) @(posedge clk);
        brc_host_i.wr(brc_pkg::ADDR_CTRL, 8'h40);
        chk_rd(brc_pkg::ADDR_SEC, 8'h00);
        chk_rd(brc_pkg::ADDR_MIN, 8'h00);
        chk_rd(brc_pkg::ADDR_HOUR, 8'h00);
        chk_rd(brc_pkg::ADDR_CDAY, 8'h21);
        chk_rd(brc_pkg::ADDR_DATE, 8'h81);
        chk_rd(brc_pkg::ADDR_MONTH, 8'h01);
        chk_rd(brc_pkg::ADDR_YEAR, 8'h00);
        @(posedge clk) #1;
        {bat_done, bat_low} = 2'b11;
        @(posedge clk) #1;
        {bat_done, bat_low} = 2'b00;
        chk_rd(brc_pkg::ADDR_DATE, 8'hC1);
        // Century flag write refused without write hold
        brc_host_i.wr(brc_pkg::ADDR_CDAY, 8'h51);
        chk_rd(brc_pkg::ADDR_CDAY, 8'h41);
        brc_host_i.wr(brc_pkg::ADDR_CTRL, 8'h00);
        count_ft(n, bad);
        `CHK(n, 20)
        `CHK(bad, 1'b0)
        brc_host_i.wr(brc_pkg::ADDR_SEC, 8'h80);
        @(posedge clk) #1;
        count_ft(n, bad);
        `CHK(n, 0)
        close_out();
    end
endmodule
